//--- dcc_pkg.sv
// Operation
// - Comparator powered and running only while enable bit 7 of control zero is set.
// - Read-only bit 6 shows plus input above minus input.
// - Rising-edge flag bit 5 sets on each low-to-high output transition.
// - Falling-edge flag bit 4 sets on each high-to-low output transition.
// - Edge flags stay set until software writes zero; hardware never clears.
// - Plus hysteresis field bits 3:2, zero off, three is maximum.
// - Minus hysteresis field bits 1:0, zero off, resets to zero.
// - Each counter overflow captures the output into mode bit 7.
// - Topology field bits 3:2 picks mux, grounded minus, plus DAC, minus DAC.
// - In DAC topologies the DAC side's mux selection is the DAC full-scale reference.
// - Speed and power mode bits 1:0 reset to two; zero is fastest.
// - Input select bits 7:4 hold minus channel, reset 0xF.
// - Input select bits 3:0 hold plus channel, reset 0xF.
// - With hold enable set, output holds while counter channel two output is low.
// - With hold enable clear, output always follows the comparison.
// - Each edge interrupt is requested only while its enable bit is set.
// - Disabled comparator output reads low at bit 6 and at result_o, and its power is off.
package dcc_pkg;
    localparam logic [7:0] DCC_C0_CTL1_ADDR = 8'h99;
    localparam logic [7:0] DCC_C0_CTL0_ADDR = 8'h9b;
    localparam logic [7:0] DCC_C0_MODE_ADDR = 8'h9d;
    localparam logic [7:0] DCC_C0_MUX_ADDR  = 8'h9f;
    localparam logic [7:0] DCC_C1_MUX_ADDR  = 8'haa;
    localparam logic [7:0] DCC_C1_MODE_ADDR = 8'hab;
    localparam logic [7:0] DCC_C1_CTL1_ADDR = 8'hac;
    localparam logic [7:0] DCC_C1_CTL0_ADDR = 8'hbf;

    localparam int DCC_ON_BIT     = 7;
    localparam int DCC_RESULT_BIT = 6;
    localparam int DCC_RISE_BIT   = 5;
    localparam int DCC_FALL_BIT   = 4;
    localparam int DCC_LATCH_BIT  = 7;
    localparam int DCC_INV_BIT    = 6;
    localparam int DCC_RIE_BIT    = 5;
    localparam int DCC_FIE_BIT    = 4;
    localparam int DCC_HOLD_BIT   = 7;

    localparam logic [7:0] DCC_CTL0_RESET = 8'h00;
    localparam logic [7:0] DCC_MODE_RESET = 8'h02;
    localparam logic [7:0] DCC_MUX_RESET  = 8'hff;
    localparam logic [7:0] DCC_CTL1_RESET = 8'h00;
    localparam logic [7:0] DCC_CTL0_WMASK = 8'hbf;
    localparam logic [7:0] DCC_CTL1_WMASK = 8'hbf;

    typedef enum logic [1:0] {
        DCC_TOPO_MUX_MUX,
        DCC_TOPO_MUX_GND,
        DCC_TOPO_DAC_MUX,
        DCC_TOPO_MUX_DAC
    } dcc_topo_e;

    typedef struct packed {
        logic       power_on;
        logic [1:0] plus_hysteresis_level;
        logic [1:0] minus_hysteresis_level;
        logic [1:0] speed_power_mode;
        logic [1:0] input_topology;
        logic [3:0] plus_channel_select;
        logic [3:0] minus_channel_select;
        logic [5:0] reference_level;
        logic       dac_on_plus;
        logic       dac_on_minus;
        logic       minus_grounded;
        logic [3:0] dac_full_scale_input;
    } dcc_analog_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dcc_sfr_s;
endpackage

//--- dcc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_sync
    import dcc_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic meta_ff;
    logic sync_ff;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule
`default_nettype wire

//--- dcc_channel.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_channel
    import dcc_pkg::*;
#(
    parameter logic [7:0] CTL0_ADDR = 8'h9b,
    parameter logic [7:0] MODE_ADDR = 8'h9d,
    parameter logic [7:0] MUX_ADDR  = 8'h9f,
    parameter logic [7:0] CTL1_ADDR = 8'h99
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire dcc_sfr_s     sfr_i,
    input  wire logic         raw_result_i,
    input  wire logic         pca_chan_two_i,
    input  wire logic         pca_overflow_i,
    output logic              hit_o,
    output logic [7:0]        rdata_o,
    output logic              result_o,
    output logic              irq_o,
    output dcc_analog_s       analog_o
);
    logic       on_ff;
    logic       rise_ff;
    logic       fall_ff;
    logic [3:0] hyst_ff;
    logic       latch_ff;
    logic       inv_ff;
    logic       rie_ff;
    logic       fie_ff;
    logic [1:0] topo_ff;
    logic [1:0] mode_ff;
    logic [7:0] mux_ff;
    logic       hold_ff;
    logic [5:0] level_ff;
    logic       out_ff;
    logic       prev_ff;
    logic       sync_raw;
    logic       nxt_out;
    logic       wr_ctl0;
    logic       wr_mode;
    logic       wr_mux;
    logic       wr_ctl1;
    logic       rise_evt;
    logic       fall_evt;

    ////////////////////////////////////////////////////////////////////////////
    // Comparator result path.
    dcc_sync u_raw_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .async_i   (raw_result_i),
        .sync_o    (sync_raw)
    );

    always_comb begin
        nxt_out = (sync_raw ^ inv_ff) & on_ff;
        if (hold_ff && !pca_chan_two_i && on_ff) begin
            nxt_out = out_ff;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_ff  <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            out_ff  <= nxt_out;
            prev_ff <= out_ff;
        end
    end

    assign rise_evt = out_ff & ~prev_ff;
    assign fall_evt = ~out_ff & prev_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Register writes.
    assign wr_ctl0 = sfr_i.wr && (sfr_i.addr == CTL0_ADDR);
    assign wr_mode = sfr_i.wr && (sfr_i.addr == MODE_ADDR);
    assign wr_mux  = sfr_i.wr && (sfr_i.addr == MUX_ADDR);
    assign wr_ctl1 = sfr_i.wr && (sfr_i.addr == CTL1_ADDR);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            on_ff   <= DCC_CTL0_RESET[DCC_ON_BIT];
            hyst_ff <= DCC_CTL0_RESET[3:0];
        end else if (wr_ctl0) begin
            on_ff   <= sfr_i.wdata[DCC_ON_BIT];
            hyst_ff <= sfr_i.wdata[3:0];
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rise_ff <= DCC_CTL0_RESET[DCC_RISE_BIT];
            fall_ff <= DCC_CTL0_RESET[DCC_FALL_BIT];
        end else begin
            if (rise_evt) begin
                rise_ff <= 1'b1;
            end else if (wr_ctl0) begin
                rise_ff <= sfr_i.wdata[DCC_RISE_BIT];
            end
            if (fall_evt) begin
                fall_ff <= 1'b1;
            end else if (wr_ctl0) begin
                fall_ff <= sfr_i.wdata[DCC_FALL_BIT];
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            latch_ff <= DCC_MODE_RESET[DCC_LATCH_BIT];
            inv_ff   <= DCC_MODE_RESET[DCC_INV_BIT];
            rie_ff   <= DCC_MODE_RESET[DCC_RIE_BIT];
            fie_ff   <= DCC_MODE_RESET[DCC_FIE_BIT];
            topo_ff  <= DCC_MODE_RESET[3:2];
            mode_ff  <= DCC_MODE_RESET[1:0];
        end else begin
            if (pca_overflow_i) begin
                latch_ff <= out_ff;
            end else if (wr_mode) begin
                latch_ff <= sfr_i.wdata[DCC_LATCH_BIT];
            end
            if (wr_mode) begin
                inv_ff  <= sfr_i.wdata[DCC_INV_BIT];
                rie_ff  <= sfr_i.wdata[DCC_RIE_BIT];
                fie_ff  <= sfr_i.wdata[DCC_FIE_BIT];
                topo_ff <= sfr_i.wdata[3:2];
                mode_ff <= sfr_i.wdata[1:0];
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mux_ff <= DCC_MUX_RESET;
        end else if (wr_mux) begin
            mux_ff <= sfr_i.wdata;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_ff  <= DCC_CTL1_RESET[DCC_HOLD_BIT];
            level_ff <= DCC_CTL1_RESET[5:0];
        end else if (wr_ctl1) begin
            hold_ff  <= sfr_i.wdata[DCC_HOLD_BIT];
            level_ff <= sfr_i.wdata[5:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, interrupt and analog controls.
    always_comb begin
        hit_o   = 1'b1;
        rdata_o = 8'h00;
        case (sfr_i.addr)
            CTL0_ADDR: rdata_o = {on_ff, out_ff, rise_ff, fall_ff, hyst_ff};
            MODE_ADDR: rdata_o = {latch_ff, inv_ff, rie_ff, fie_ff, topo_ff, mode_ff};
            MUX_ADDR:  rdata_o = mux_ff;
            CTL1_ADDR: rdata_o = {hold_ff, 1'b0, level_ff};
            default:   hit_o   = 1'b0;
        endcase
    end

    assign result_o = out_ff;
    assign irq_o    = (rise_ff & rie_ff) | (fall_ff & fie_ff);

    always_comb begin
        analog_o.power_on               = on_ff;
        analog_o.plus_hysteresis_level  = hyst_ff[3:2];
        analog_o.minus_hysteresis_level = hyst_ff[1:0];
        analog_o.speed_power_mode       = mode_ff;
        analog_o.input_topology         = topo_ff;
        analog_o.plus_channel_select    = mux_ff[3:0];
        analog_o.minus_channel_select   = mux_ff[7:4];
        analog_o.reference_level        = level_ff;
        analog_o.dac_on_plus            = 1'b0;
        analog_o.dac_on_minus           = 1'b0;
        analog_o.minus_grounded         = 1'b0;
        analog_o.dac_full_scale_input   = 4'h0;
        case (dcc_topo_e'(topo_ff))
            DCC_TOPO_MUX_GND: analog_o.minus_grounded = 1'b1;
            DCC_TOPO_DAC_MUX: begin
                analog_o.dac_on_plus          = 1'b1;
                analog_o.dac_full_scale_input = mux_ff[3:0];
            end
            DCC_TOPO_MUX_DAC: begin
                analog_o.dac_on_minus         = 1'b1;
                analog_o.dac_full_scale_input = mux_ff[7:4];
            end
            default: analog_o.minus_grounded = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

//--- dcc_top.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_top
    import dcc_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        sfr_wr_i,
    input  wire logic        sfr_rd_i,
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic [7:0]       sfr_rdata_o,
    output logic             sfr_hit_o,
    input  wire logic [1:0]  raw_result_i,
    input  wire logic        pca_chan_two_i,
    input  wire logic        pca_overflow_i,
    output logic [1:0]       result_o,
    output logic [1:0]       irq_o,
    output dcc_analog_s      analog0_o,
    output dcc_analog_s      analog1_o
);
    dcc_sfr_s   sfr;
    logic       chan_two_sync;
    logic [1:0] hit;
    logic [7:0] rd0;
    logic [7:0] rd1;

    assign sfr = '{wr: sfr_wr_i, rd: sfr_rd_i, addr: sfr_addr_i, wdata: sfr_wdata_i};

    dcc_sync u_chan_two_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .async_i   (pca_chan_two_i),
        .sync_o    (chan_two_sync)
    );

    dcc_channel #(
        .CTL0_ADDR (DCC_C0_CTL0_ADDR),
        .MODE_ADDR (DCC_C0_MODE_ADDR),
        .MUX_ADDR  (DCC_C0_MUX_ADDR),
        .CTL1_ADDR (DCC_C0_CTL1_ADDR)
    ) u_comp0 (
        .ref_clk_i      (ref_clk_i),
        .rst_i          (rst_i),
        .sfr_i          (sfr),
        .raw_result_i   (raw_result_i[0]),
        .pca_chan_two_i (chan_two_sync),
        .pca_overflow_i (pca_overflow_i),
        .hit_o          (hit[0]),
        .rdata_o        (rd0),
        .result_o       (result_o[0]),
        .irq_o          (irq_o[0]),
        .analog_o       (analog0_o)
    );

    dcc_channel #(
        .CTL0_ADDR (DCC_C1_CTL0_ADDR),
        .MODE_ADDR (DCC_C1_MODE_ADDR),
        .MUX_ADDR  (DCC_C1_MUX_ADDR),
        .CTL1_ADDR (DCC_C1_CTL1_ADDR)
    ) u_comp1 (
        .ref_clk_i      (ref_clk_i),
        .rst_i          (rst_i),
        .sfr_i          (sfr),
        .raw_result_i   (raw_result_i[1]),
        .pca_chan_two_i (chan_two_sync),
        .pca_overflow_i (pca_overflow_i),
        .hit_o          (hit[1]),
        .rdata_o        (rd1),
        .result_o       (result_o[1]),
        .irq_o          (irq_o[1]),
        .analog_o       (analog1_o)
    );

    assign sfr_hit_o   = |hit;
    assign sfr_rdata_o = hit[0] ? rd0 : (hit[1] ? rd1 : 8'h00);
endmodule
`default_nettype wire

//--- dcc_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_top_properties
    import dcc_pkg::*;
(
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic        sfr_wr_i,
    input wire logic        sfr_rd_i,
    input wire logic [7:0]  sfr_addr_i,
    input wire logic [7:0]  sfr_wdata_i,
    input wire logic [7:0]  sfr_rdata_o,
    input wire logic        sfr_hit_o,
    input wire logic [1:0]  raw_result_i,
    input wire logic        pca_chan_two_i,
    input wire logic        pca_overflow_i,
    input wire logic [1:0]  result_o,
    input wire logic [1:0]  irq_o,
    input wire dcc_analog_s analog0_o,
    input wire dcc_analog_s analog1_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    wire logic c0 = (sfr_addr_i == DCC_C0_CTL0_ADDR);
    ////////////////////////////////////////////////////////////////
    a_power_follows: assert property (sfr_wr_i && c0 |=> analog0_o.power_on == $past(sfr_wdata_i[7]))
        else $error("enable bit not applied");
    a_off_low: assert property (!analog0_o.power_on && $past(!analog0_o.power_on) |-> !result_o[0])
        else $error("disabled comparator output not low");
    a_result_read: assert property (c0 |-> sfr_rdata_o[6] == result_o[0])
        else $error("output state bit differs from output");
    a_irq_flag: assert property (c0 && irq_o[0] |-> sfr_rdata_o[5] || sfr_rdata_o[4])
        else $error("interrupt without edge flag");
    a_latch_capture: assert property (pca_overflow_i && !sfr_wr_i ##1 sfr_addr_i == DCC_C0_MODE_ADDR
        |-> sfr_rdata_o[7] == $past(result_o[0])) else $error("overflow capture wrong");
    a_mux_write: assert property (sfr_wr_i && sfr_addr_i == DCC_C0_MUX_ADDR
        |=> {analog0_o.minus_channel_select, analog0_o.plus_channel_select} == $past(sfr_wdata_i))
        else $error("channel selects not applied");
    a_dac_ref: assert property (analog0_o.dac_on_minus |-> analog0_o.input_topology == DCC_TOPO_MUX_DAC
        && analog0_o.dac_full_scale_input == analog0_o.minus_channel_select) else $error("dac reference wrong");
    a_power_one: assert property (sfr_wr_i && sfr_addr_i == DCC_C1_CTL0_ADDR
        |=> analog1_o.power_on == $past(sfr_wdata_i[7])) else $error("second enable not applied");
    c_irq: cover property (irq_o[0]);
    c_latch: cover property (pca_overflow_i && result_o[0]);
    c_hold: cover property (!pca_chan_two_i && result_o[1]);
endmodule
bind dcc_top dcc_top_properties u_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .sfr_hit_o(sfr_hit_o), .raw_result_i(raw_result_i), .pca_chan_two_i(pca_chan_two_i),
    .pca_overflow_i(pca_overflow_i), .result_o(result_o), .irq_o(irq_o), .analog0_o(analog0_o),
    .analog1_o(analog1_o));
`default_nettype wire

//--- dcc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_top_test
    import dcc_pkg::*;
;
    localparam logic [7:0] NOMAP = 8'h9a;
    logic              ref_clk_i = 0;
    logic              rst_i = 1;
    logic              sfr_wr_i = 0;
    logic              sfr_rd_i = 0;
    logic              pca_chan_two_i = 1;
    logic              pca_overflow_i = 0;
    logic              sfr_hit_o;
    logic [7:0]        sfr_addr_i = 0;
    logic [7:0]        sfr_wdata_i = 0;
    logic [7:0]        sfr_rdata_o;
    logic [1:0]        raw_result_i = 0;
    logic [1:0]        result_o;
    logic [1:0]        irq_o;
    dcc_analog_s       analog0_o;
    dcc_analog_s       analog1_o;
    logic [15:0]       exp_q[$];
    logic [15:0]       msk_q[$];
    logic [7:0]        c0[2];
    logic [7:0]        md[2];
    logic [7:0]        mx[2];
    logic [7:0]        c1[2];
    logic [3:0]        h;
    logic [3:0]        t;
    logic [7:0]        x;
    logic [15:0]       sa;
    dcc_analog_s       an;
    int                fail_count = 0;
    int                check_count = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    dcc_top DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
        .raw_result_i(raw_result_i), .pca_chan_two_i(pca_chan_two_i), .pca_overflow_i(pca_overflow_i),
        .result_o(result_o), .irq_o(irq_o), .analog0_o(analog0_o), .analog1_o(analog1_o));
    ////////////////////////////////////////////////////////////////
    task check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task w6;
        repeat (6) @(posedge ref_clk_i);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        sfr_wr_i <= 1;
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        @(posedge ref_clk_i);
        sfr_wr_i <= 0;
    endtask
    task chk(input logic [7:0] a, input int n, input logic i, input logic r, input logic [7:0] d);
        @(posedge ref_clk_i);
        sfr_rd_i <= 1;
        sfr_addr_i <= a;
        exp_q.push_back({3'b000, a != NOMAP, 2'(i) << n, 2'(r) << n, d});
        msk_q.push_back(16'h10ff | (16'h0500 << n));
        @(posedge ref_clk_i);
        sfr_rd_i <= 0;
    endtask
    always @(negedge ref_clk_i) begin
        if (sfr_rd_i === 1'b1 && exp_q.size() > 0) begin
            check({3'b000, sfr_hit_o, irq_o, result_o, sfr_rdata_o} & msk_q[0], exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    initial begin
        #(20000 * 50);
        fail_count++;
        complete_run();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        c0 = '{DCC_C0_CTL0_ADDR, DCC_C1_CTL0_ADDR};
        md = '{DCC_C0_MODE_ADDR, DCC_C1_MODE_ADDR};
        mx = '{DCC_C0_MUX_ADDR, DCC_C1_MUX_ADDR};
        c1 = '{DCC_C0_CTL1_ADDR, DCC_C1_CTL1_ADDR};
        void'($urandom(32'h8164_e382));
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 0;
        for (int n = 0; n < 2; n++) begin
            chk(c0[n], n, 0, 0, 8'h00);
            chk(md[n], n, 0, 0, 8'h02);
            chk(mx[n], n, 0, 0, 8'hff);
            chk(c1[n], n, 0, 0, 8'h00);
        end
        chk(NOMAP, 0, 0, 0, 8'h00);
        raw_result_i <= 2'b11;
        w6();
        chk(c0[0], 0, 0, 0, 8'h00);
        raw_result_i <= 2'b00;
        w6();
        for (int n = 0; n < 2; n++) begin
            h = 4'($urandom);
            t = 4'($urandom);
            wr(c0[n], {4'h8, h});
            raw_result_i[n] <= 1'b1;
            w6();
            chk(c0[n], n, 0, 1, {4'he, h});
            wr(c0[n], {4'hc, h});
            chk(c0[n], n, 0, 1, {4'hc, h});
            wr(md[n], {4'h3, t});
            raw_result_i[n] <= 1'b0;
            w6();
            chk(c0[n], n, 1, 0, {4'h9, h});
            chk(md[n], n, 1, 0, {4'h3, t});
            x = 8'($urandom);
            wr(mx[n], x);
            for (int k = 0; k < 4; k++) begin
                wr(md[n], {4'h3, 2'(k), t[1:0]});
                @(negedge ref_clk_i);
                an = (n == 0) ? analog0_o : analog1_o;
                sa = {an.power_on, an.plus_hysteresis_level, an.minus_hysteresis_level, an.speed_power_mode,
                      an.input_topology, an.plus_channel_select, an.dac_on_plus, an.dac_on_minus, an.minus_grounded};
                check(sa, {1'b1, h, t[1:0], 2'(k), x[3:0], k == 2, k == 3, k == 1});
                sa = {2'b00, an.minus_channel_select, an.reference_level, an.dac_full_scale_input};
                check(sa, {2'b00, x[7:4], 6'h00, (k == 2) ? x[3:0] : ((k == 3) ? x[7:4] : 4'h0)});
            end
            wr(md[n], {4'h6, t});
            w6();
            @(posedge ref_clk_i);
            pca_overflow_i <= 1;
            @(posedge ref_clk_i);
            pca_overflow_i <= 0;
            chk(md[n], n, 1, 1, {4'he, t});
            wr(c0[n], {4'h8, h});
            wr(c1[n], 8'hff);
            pca_chan_two_i <= 0;
            w6();
            raw_result_i[n] <= 1'b1;
            w6();
            chk(c1[n], n, 0, 1, 8'hbf);
            pca_chan_two_i <= 1;
            w6();
            chk(c0[n], n, 0, 0, {4'h9, h});
            wr(md[n], 8'h02);
            wr(c1[n], 8'h00);
            wr(c0[n], 8'h00);
            raw_result_i[n] <= 1'b0;
            w6();
        end
        complete_run();
    end
endmodule
`default_nettype wire
